// file: sra_pkg.sv
// constants and types shared by the serial register access slave
// assumes one 125 mhz clock domain; serial pins arrive asynchronously
package sra_pkg;
    // synchronised pin vector layout
    localparam int PIN_N = 5;
    localparam int PIN_SCK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_SS = 2;
    localparam int PIN_SCL = 3;
    localparam int PIN_SDA = 4;
    // idle levels after reset: select, scl and sda high
    localparam logic [4:0] PIN_RST = 5'h1c;

    // spi instruction framing
    localparam logic [5:0] SPI_LAST = 6'h37;
    localparam int SPI_DIR = 55;
    localparam int SPI_ADDR_MSB = 54;
    localparam int SPI_ADDR_LSB = 32;
    localparam int SPI_DATA_MSB = 31;

    // two-wire framing
    localparam logic [3:0] TW_ADDR_HI = 4'h8;
    localparam logic [3:0] TW_ACK_SLOT = 4'h8;
    localparam logic [2:0] TW_LAST_ADDR_BYTE = 3'h2;
    localparam logic [2:0] TW_FIRST_DATA_BYTE = 3'h3;
    localparam logic [2:0] TW_LAST_DATA_BYTE = 3'h6;
    localparam logic [1:0] TW_LAST_TX_BYTE = 2'h3;

    // value returned for an address nobody decodes
    localparam logic [31:0] REG_MISS_DATA = 32'h0;

    typedef enum logic [1:0] {
        SRA_TW_IDLE,
        SRA_TW_SADDR,
        SRA_TW_RX,
        SRA_TW_TX
    } sra_tw_e;
endpackage : sra_pkg

// file: sra_pin_if.sv
// synchronised serial pin levels and their edges
// assumes the producer and consumer share i_mclk
`timescale 1ns/10ps
interface sra_pin_if;
    logic [sra_pkg::PIN_N-1:0] lvl;
    logic [sra_pkg::PIN_N-1:0] rise;
    logic [sra_pkg::PIN_N-1:0] fall;
    modport src(output lvl, output rise, output fall);
    modport dst(input lvl, input rise, input fall);
endinterface : sra_pin_if

// file: sra_sync.sv
// two-flop synchroniser with edge detection for the serial pins
// assumes pins are asynchronous to i_mclk and much slower than it
`timescale 1ns/10ps
module sra_sync (
    input wire logic i_mclk,                          // system clock
    input wire logic i_srst,                          // synchronous reset
    input wire logic [sra_pkg::PIN_N-1:0] i_pins,     // raw pin levels
    sra_pin_if.src p                                  // synchronised levels and edges
);
    import sra_pkg::*;

    logic [PIN_N-1:0] meta;
    logic [PIN_N-1:0] sync;
    logic [PIN_N-1:0] hist;

    // first stage feeds only the second; edges compare stages two and three
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            meta <= PIN_RST;
            sync <= PIN_RST;
            hist <= PIN_RST;
        end else begin
            meta <= i_pins;
            sync <= meta;
            hist <= sync;
        end
    end

    assign p.lvl = sync;
    assign p.rise = sync & ~hist;
    assign p.fall = hist & ~sync;
endmodule : sra_sync

// file: sra_top.sv
// spi and two-wire slave front end to the 32-bit register space
// assumes the register space answers one cycle after o_reg_req
`timescale 1ns/10ps
module sra_top (
    input wire logic i_mclk,                 // 125 mhz system clock
    input wire logic i_srst,                 // synchronous reset, active high
    input wire logic i_spi_sck,              // spi serial clock pin
    input wire logic i_spi_mosi,             // spi data from host
    input wire logic i_slave_select_low,     // spi select, active low
    output logic o_spi_miso,                 // spi data to host
    output logic o_spi_miso_oe_n,            // miso enable, low drives
    input wire logic i_tw_scl,               // two-wire clock pin
    input wire logic i_tw_sda,               // two-wire data pin level
    output logic o_tw_sda,                   // two-wire data drive value
    output logic o_tw_sda_oe_n,              // sda enable, low drives
    input wire logic [2:0] i_port_addr,      // slave address strap pins
    input wire logic i_fast_mode,            // spi output launch on rising edge
    input wire logic i_gpio_mode_req,        // hand the two-wire pins to gpio
    output logic o_tw_pin_sel,               // pins serve the two-wire slave
    output logic o_reg_req,                  // register access pulse
    output logic o_reg_we,                   // access is a write
    output logic [22:0] o_reg_addr,          // channel, device, register
    output logic [31:0] o_reg_wdata,         // write data
    input wire logic [31:0] i_reg_rdata,     // read data, cycle after request
    input wire logic i_reg_hit               // address decoded, with read data
);
    import sra_pkg::*;

    sra_pin_if pins ();
    logic [2:0] port_meta;
    logic [2:0] port_sync;
    logic ss;
    logic [5:0] spi_cnt;
    logic [54:0] spi_sh;
    logic [55:0] spi_instr;
    logic spi_done;
    logic cur_dir;
    logic [23:0] prev_hdr;
    logic [31:0] prev_data;
    logic prev_rd;
    logic spi_upd;
    logic [5:0] spi_idx;
    logic rd_pend;
    logic rd_src_tw;
    logic [31:0] rd_word;
    sra_tw_e tw_st;
    logic [3:0] tw_bcnt;
    logic [7:0] tw_sh;
    logic tw_ack_drv;
    logic tw_rw;
    logic [2:0] tw_byte;
    logic [1:0] tw_tx;
    logic tw_nack;
    logic [23:0] tw_addr;
    logic [31:0] tw_wd;
    logic [31:0] tw_rd;
    logic tw_req;
    logic tw_req_we;
    logic [22:0] tw_req_addr;
    logic [31:0] tw_req_wd;
    logic tw_start;
    logic tw_stop;

    // selects bit b of byte idx, byte 0 being the most significant
    function automatic logic sra_tw_bit(input logic [31:0] w, input logic [1:0] idx,
                                        input logic [2:0] b);
        sra_tw_bit = w[{~idx, b}];
    endfunction : sra_tw_bit

    sra_sync u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_pins({i_tw_sda, i_tw_scl, i_slave_select_low, i_spi_mosi, i_spi_sck}),
        .p(pins.src)
    );

    // strap pins pass two flops before the address compare reads them
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            port_meta <= 3'h0;
            port_sync <= 3'h0;
        end else begin
            port_meta <= i_port_addr;
            port_sync <= port_meta;
        end
    end

    // pin function: two-wire after reset until gpio config claims the pins
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_tw_pin_sel <= 1'b1;
        end else begin
            o_tw_pin_sel <= ~i_gpio_mode_req;
        end
    end

    assign ss = pins.lvl[PIN_SS];
    assign spi_instr = {spi_sh, pins.lvl[PIN_MOSI]};
    assign spi_done = ~ss & pins.rise[PIN_SCK] & (spi_cnt == SPI_LAST);
    assign spi_idx = SPI_LAST - spi_cnt;

    // input shift on rising sck only, whatever the launch mode
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            spi_cnt <= 6'h0;
            spi_sh <= 55'h0;
            cur_dir <= 1'b0;
        end else if (ss) begin
            spi_cnt <= 6'h0;
        end else if (pins.rise[PIN_SCK]) begin
            spi_sh <= spi_instr[54:0];
            spi_cnt <= (spi_cnt == SPI_LAST) ? 6'h0 : spi_cnt + 6'h1;
            if (spi_cnt == 6'h0) begin
                cur_dir <= pins.lvl[PIN_MOSI];
            end
        end
    end

    // echo state: header of the last instruction, and its data or fetched word
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            prev_hdr <= 24'h0;
            prev_data <= 32'h0;
            prev_rd <= 1'b0;
        end else begin
            if (spi_done) begin
                prev_hdr <= spi_instr[SPI_DIR:SPI_ADDR_LSB];
                prev_rd <= ~spi_instr[SPI_DIR];
                if (spi_instr[SPI_DIR]) begin
                    prev_data <= spi_instr[SPI_DATA_MSB:0];
                end
            end
            if (rd_pend && !rd_src_tw) begin
                prev_data <= rd_word;
            end
        end
    end

    // launch strobe one cycle after the edge so a just-finished header is seen
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            spi_upd <= 1'b0;
        end else begin
            spi_upd <= pins.fall[PIN_SS] |
                       (~ss & (i_fast_mode ? pins.rise[PIN_SCK] : pins.fall[PIN_SCK]));
        end
    end

    // miso bit: header bits, then data, zeroed when a write follows a read
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_spi_miso <= 1'b0;
        end else if (spi_upd) begin
            if (spi_idx[5]) begin
                o_spi_miso <= prev_hdr[spi_idx[4:0]];
            end else if (cur_dir && prev_rd) begin
                o_spi_miso <= 1'b0;
            end else begin
                o_spi_miso <= prev_data[spi_idx[4:0]];
            end
        end
    end

    // miso floats whenever the select is high
    assign o_spi_miso_oe_n = ss;

    // register port: spi wins a same-cycle clash, ports are not used together
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_reg_req <= 1'b0;
            o_reg_we <= 1'b0;
            o_reg_addr <= 23'h0;
            o_reg_wdata <= 32'h0;
            rd_pend <= 1'b0;
            rd_src_tw <= 1'b0;
        end else begin
            o_reg_req <= spi_done | tw_req;
            rd_pend <= o_reg_req & ~o_reg_we;
            if (spi_done) begin
                o_reg_we <= spi_instr[SPI_DIR];
                o_reg_addr <= spi_instr[SPI_ADDR_MSB:SPI_ADDR_LSB];
                o_reg_wdata <= spi_instr[SPI_DATA_MSB:0];
                rd_src_tw <= 1'b0;
            end else if (tw_req) begin
                o_reg_we <= tw_req_we;
                o_reg_addr <= tw_req_addr;
                o_reg_wdata <= tw_req_wd;
                rd_src_tw <= 1'b1;
            end
        end
    end

    // undecoded addresses read as zero on either port
    assign rd_word = i_reg_hit ? i_reg_rdata : REG_MISS_DATA;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            tw_rd <= 32'h0;
        end else if (rd_pend && rd_src_tw) begin
            tw_rd <= rd_word;
        end
    end

    assign tw_start = pins.fall[PIN_SDA] & pins.lvl[PIN_SCL];
    assign tw_stop = pins.rise[PIN_SDA] & pins.lvl[PIN_SCL];
    assign o_tw_sda = 1'b0; // open drain: only ever pulls low

    // two-wire slave; sda changes only after scl falls, so start/stop stay clean
    always_ff @(posedge i_mclk) begin
        tw_req <= 1'b0;
        if (i_srst || !o_tw_pin_sel) begin
            tw_st <= SRA_TW_IDLE;
            tw_bcnt <= 4'h0;
            tw_sh <= 8'h0;
            o_tw_sda_oe_n <= 1'b1;
            tw_ack_drv <= 1'b0;
            tw_rw <= 1'b0;
            tw_byte <= 3'h0;
            tw_tx <= 2'h0;
            tw_nack <= 1'b0;
            tw_addr <= 24'h0;
            tw_wd <= 32'h0;
            tw_req_we <= 1'b0;
            tw_req_addr <= 23'h0;
            tw_req_wd <= 32'h0;
        end else if (tw_stop) begin
            tw_st <= SRA_TW_IDLE;
            o_tw_sda_oe_n <= 1'b1;
            tw_ack_drv <= 1'b0;
        end else if (tw_start) begin
            tw_st <= SRA_TW_SADDR;
            tw_bcnt <= 4'h0;
            o_tw_sda_oe_n <= 1'b1;
            tw_ack_drv <= 1'b0;
        end else if (tw_st != SRA_TW_IDLE && pins.rise[PIN_SCL]) begin
            if (tw_bcnt == TW_ACK_SLOT) begin
                tw_bcnt <= 4'h0;
                tw_nack <= pins.lvl[PIN_SDA];
            end else begin
                tw_bcnt <= tw_bcnt + 4'h1;
                tw_sh <= {tw_sh[6:0], pins.lvl[PIN_SDA]};
            end
        end else if (tw_st != SRA_TW_IDLE && pins.fall[PIN_SCL]) begin
            if (tw_bcnt == TW_ACK_SLOT) begin
                case (tw_st)
                    SRA_TW_SADDR: begin
                        if (tw_sh[7:1] == {TW_ADDR_HI, port_sync}) begin
                            o_tw_sda_oe_n <= 1'b0;
                            tw_ack_drv <= 1'b1;
                            tw_rw <= tw_sh[0];
                            tw_byte <= 3'h0;
                            if (tw_sh[0]) begin
                                tw_req <= 1'b1;
                                tw_req_we <= 1'b0;
                                tw_req_addr <= tw_addr[22:0];
                                tw_addr <= {tw_addr[23:16], tw_addr[15:0] + 16'h1};
                            end
                        end else begin
                            tw_st <= SRA_TW_IDLE;
                        end
                    end
                    SRA_TW_RX: begin
                        o_tw_sda_oe_n <= 1'b0;
                        tw_ack_drv <= 1'b1;
                        if (tw_byte <= TW_LAST_ADDR_BYTE) begin
                            tw_addr <= {tw_addr[15:0], tw_sh};
                            tw_byte <= tw_byte + 3'h1;
                        end else if (tw_byte == TW_LAST_DATA_BYTE) begin
                            tw_req <= 1'b1;
                            tw_req_we <= 1'b1;
                            tw_req_addr <= tw_addr[22:0];
                            tw_req_wd <= {tw_wd[23:0], tw_sh};
                            tw_addr <= {tw_addr[23:16], tw_addr[15:0] + 16'h1};
                            tw_byte <= TW_FIRST_DATA_BYTE;
                        end else begin
                            tw_wd <= {tw_wd[23:0], tw_sh};
                            tw_byte <= tw_byte + 3'h1;
                        end
                    end
                    SRA_TW_TX: begin
                        o_tw_sda_oe_n <= 1'b1;
                        if (tw_tx == TW_LAST_TX_BYTE && !tw_nack) begin
                            tw_req <= 1'b1;
                            tw_req_we <= 1'b0;
                            tw_req_addr <= tw_addr[22:0];
                            tw_addr <= {tw_addr[23:16], tw_addr[15:0] + 16'h1};
                        end
                    end
                    default: begin
                        o_tw_sda_oe_n <= 1'b1;
                    end
                endcase
            end else if (tw_bcnt == 4'h0) begin
                if (tw_ack_drv) begin
                    tw_ack_drv <= 1'b0;
                    o_tw_sda_oe_n <= 1'b1;
                    if (tw_st == SRA_TW_SADDR) begin
                        if (tw_rw) begin
                            tw_st <= SRA_TW_TX;
                            tw_tx <= 2'h0;
                            o_tw_sda_oe_n <= sra_tw_bit(tw_rd, 2'h0, 3'h7);
                        end else begin
                            tw_st <= SRA_TW_RX;
                        end
                    end
                end else if (tw_st == SRA_TW_TX) begin
                    if (tw_nack) begin
                        tw_st <= SRA_TW_IDLE;
                        o_tw_sda_oe_n <= 1'b1;
                    end else begin
                        tw_tx <= tw_tx + 2'h1;
                        o_tw_sda_oe_n <= sra_tw_bit(tw_rd, tw_tx + 2'h1, 3'h7);
                    end
                end
            end else if (tw_st == SRA_TW_TX) begin
                o_tw_sda_oe_n <= sra_tw_bit(tw_rd, tw_tx, 3'h7 - tw_bcnt[2:0]);
            end
        end
    end

    // checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    a_spi_idle_count: assert property (ss |=> spi_cnt == 6'h0)
        else $error("spi bit count not cleared while deselected");
    a_miso_float: assert property (ss |-> o_spi_miso_oe_n ##1
        (ss or o_spi_miso_oe_n == 1'b0))
        else $error("miso enable does not follow select");
    a_spi_read_fetch: assert property (spi_done && !spi_instr[SPI_DIR]
        |=> o_reg_req && !o_reg_we && o_reg_addr == $past(spi_instr[54:32]))
        else $error("spi read did not fetch its register");
    a_spi_write_issue: assert property (spi_done && spi_instr[SPI_DIR]
        |=> o_reg_req && o_reg_we && o_reg_wdata == $past(spi_instr[31:0]))
        else $error("spi write not issued with its data");
    a_spi_echo_hdr: assert property (spi_done ##1 !spi_done [*2]
        |-> prev_hdr == $past(spi_instr[55:32], 2))
        else $error("echo header differs from previous instruction");
    a_spi_wr_after_rd: assert property (spi_upd && !spi_idx[5] && cur_dir && prev_rd
        |=> !o_spi_miso)
        else $error("write after read did not shift zeros");
    a_miss_reads_zero: assert property (rd_pend && !rd_src_tw && !i_reg_hit
        |=> prev_data == 32'h0)
        else $error("undecoded spi read not zero");
    a_miso_launch: assert property ($changed(o_spi_miso) |-> $past(spi_upd))
        else $error("miso changed without a launch edge");
    a_tw_addr_miss: assert property (tw_st == SRA_TW_SADDR && pins.fall[PIN_SCL] &&
        !tw_start && !tw_stop && tw_bcnt == TW_ACK_SLOT && tw_sh[7:1] != {TW_ADDR_HI, port_sync}
        |=> tw_st == SRA_TW_IDLE && o_tw_sda_oe_n)
        else $error("two-wire slave answered a foreign address");
    a_tw_stop_idle: assert property (tw_stop && o_tw_pin_sel |=> tw_st == SRA_TW_IDLE
        && o_tw_sda_oe_n)
        else $error("stop did not return two-wire slave to idle");
    a_tw_word_incr: assert property (tw_req && tw_st != SRA_TW_IDLE
        |-> tw_addr[15:0] == tw_req_addr[15:0] + 16'h1 && tw_addr[22:16] == tw_req_addr[22:16])
        else $error("register number not advanced after a word");

    c_spi_read: cover property (spi_done && !spi_instr[SPI_DIR] ##[1:800] spi_done);
    c_spi_write: cover property (spi_done && spi_instr[SPI_DIR]);
    c_tw_write: cover property (tw_req && tw_req_we);
    c_tw_read_end: cover property (tw_st == SRA_TW_TX ##1 tw_st == SRA_TW_IDLE);
endmodule : sra_top

// file: sra_host_model.sv
// host model: spi master and two-wire master driving the slave pins
// assumes the bench calls one task at a time; sck idles low between frames
`timescale 1ns/10ps
module sra_host_model (
    output logic o_sck,      // spi clock
    output logic o_mosi,     // spi data to slave
    output logic o_ss_n,     // spi select, active low
    output logic o_scl,      // two-wire clock
    output logic o_sda_low,  // host pulls sda low
    input wire logic i_miso, // spi data from slave
    input wire logic i_sda   // resolved sda wire
);
    initial begin
        {o_sck, o_mosi, o_ss_n, o_scl, o_sda_low} = 5'h06; // deselected, both wires released
    end
    // sample late in the phase, after the launching edge has settled
    task automatic spi(input logic fast, input logic [55:0] tx, output logic [55:0] rx);
        o_ss_n = 0;
        #200;
        for (int i = 55; i >= 0; i--) begin
            o_mosi = tx[i];
            #38 if (fast) rx[i] = i_miso;
            #2 o_sck = 1;
            #38 if (!fast) rx[i] = i_miso;
            #2 o_sck = 0;
        end
        #200 o_ss_n = 1;
        o_mosi = ~o_mosi; // idle data is not left at a helpful level
        #200;
    endtask : spi
    task automatic tw_bit(input logic b, output logic r);
        o_sda_low = !b;
        #100 o_scl = 1;
        #100 r = i_sda;
        #100 o_scl = 0;
        #100;
    endtask : tw_bit
    // start: sda falls while scl high, also used as repeated start
    task automatic tw_start();
        o_sda_low = 0;
        #100 o_scl = 1;
        #100 o_sda_low = 1;
        #100 o_scl = 0;
        #100;
    endtask : tw_start
    task automatic tw_stop();
        o_sda_low = 1;
        #100 o_scl = 1;
        #100 o_sda_low = 0;
        #200;
    endtask : tw_stop
    task automatic tw_wr(input logic [7:0] d, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) tw_bit(d[i], r);
        tw_bit(1'b1, ack_n);
    endtask : tw_wr
    task automatic tw_rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) tw_bit(1'b1, d[i]);
        tw_bit(last, r);
    endtask : tw_rd
endmodule : sra_host_model

// file: testbench.sv
// self-checking bench: spi and two-wire host model plus a small register space
// assumes register words 0..15 of device 1e on channel 0 exist; word 3 clears on read
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
    import sra_pkg::*;
    logic mclk = 0, srst = 1, fast = 0, gpio = 0, hit = 0;
    logic sck, mosi, ss_n, scl, sda_low, sda, miso, miso_oe_n, tw_sda, tw_oe_n;
    logic pin_sel, req, we, ack_n;
    logic [2:0] paddr = 3'h5;
    logic [22:0] addr;
    logic [31:0] wdata, rdata = 0;
    logic [31:0] mem [16];
    logic [55:0] rx;
    int failures = 0, num_checks = 0;
    wire ok = addr[22:16] == 7'h1e && addr[15:4] == 12'h0;
    assign sda = (sda_low || (!tw_oe_n && !tw_sda)) ? 1'b0 : 1'b1; // open drain with pull-up
    always #4 mclk = ~mclk;
    // register space answers the cycle after a request
    always @(posedge mclk) begin
        if (req) begin
            hit <= ok;
            rdata <= ok ? mem[addr[3:0]] : 32'hdeadbeef; // garbage the slave must hide
            if (we && ok) mem[addr[3:0]] <= wdata;
            else if (!we && addr == 23'h1e0003) mem[3] <= 32'h0;
        end
    end
    sra_top i_sra_top (.i_mclk(mclk), .i_srst(srst), .i_spi_sck(sck), .i_spi_mosi(mosi),
        .i_slave_select_low(ss_n), .o_spi_miso(miso), .o_spi_miso_oe_n(miso_oe_n),
        .i_tw_scl(scl), .i_tw_sda(sda), .o_tw_sda(tw_sda), .o_tw_sda_oe_n(tw_oe_n),
        .i_port_addr(paddr), .i_fast_mode(fast), .i_gpio_mode_req(gpio),
        .o_tw_pin_sel(pin_sel), .o_reg_req(req), .o_reg_we(we), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_hit(hit));
    // a released miso shows the inverse, so a sample taken while floating is caught
    sra_host_model i_sra_host_model (.o_sck(sck), .o_mosi(mosi), .o_ss_n(ss_n),
        .o_scl(scl), .o_sda_low(sda_low), .i_miso(miso_oe_n ? ~miso : miso), .i_sda(sda));
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic test_reset();
        `CHK("pin_sel", 1'b1, pin_sel)
        `CHK("miso_oe_n", 1'b1, miso_oe_n)
        `CHK("tw_sda", 1'b0, tw_sda)
        @(posedge mclk) gpio <= 1;
        repeat (3) @(posedge mclk);
        #1 `CHK("pin_sel gpio", 1'b0, pin_sel)
        @(posedge mclk) gpio <= 0;
        repeat (3) @(posedge mclk);
        #1 `CHK("pin_sel back", 1'b1, pin_sel)
        $display("test_reset done");
    endtask : test_reset
    // pipelined echo of writes and reads, then clear-on-read and a miss
    task automatic spi_seq(input logic f);
        @(posedge mclk) fast <= f;
        mem[3] = 32'hc0c00003;
        i_sra_host_model.spi(f, {1'b1, 23'h1e0001, 32'h11112222}, rx);
        `CHK("first", f ? {1'b1, 23'h1e0001, 32'h55555555} : 56'h0, rx)
        i_sra_host_model.spi(f, {1'b1, 23'h1e0002, 32'h33334444}, rx);
        `CHK("echo ww", {1'b1, 23'h1e0001, 32'h11112222}, rx)
        `CHK("mem2", 32'h33334444, mem[2])
        i_sra_host_model.spi(f, {1'b0, 23'h1e0003, 32'h0}, rx);
        `CHK("rd after wr", {1'b1, 23'h1e0002, 32'h33334444}, rx)
        i_sra_host_model.spi(f, {1'b0, 23'h1e0003, 32'h0}, rx);
        `CHK("read", {1'b0, 23'h1e0003, 32'hc0c00003}, rx)
        i_sra_host_model.spi(f, {1'b0, 23'h7f0003, 32'h0}, rx);
        `CHK("cleared", {1'b0, 23'h1e0003, 32'h0}, rx)
        i_sra_host_model.spi(f, {1'b0, 23'h1e0000, 32'h0}, rx);
        `CHK("miss", {1'b0, 23'h7f0003, 32'h0}, rx)
        i_sra_host_model.spi(f, {1'b1, 23'h1e0001, 32'h55555555}, rx);
        `CHK("wr after rd", {1'b0, 23'h1e0000, 32'h0}, rx)
        `CHK("oe released", 1'b1, miso_oe_n)
        $display("spi_seq fast=%0d done", f);
    endtask : spi_seq
    task automatic tw_send(input logic [7:0] q[$]);
        foreach (q[k]) begin
            i_sra_host_model.tw_wr(q[k], ack_n);
            `CHK("ack", 1'b0, ack_n)
        end
    endtask : tw_send
    task automatic tw_read(input logic [7:0] a0, a1, a2, input logic [31:0] e[$]);
        logic [7:0] b;
        logic [31:0] d;
        i_sra_host_model.tw_start();
        tw_send('{8'h8a, a0, a1, a2});
        i_sra_host_model.tw_start();
        tw_send('{8'h8b});
        foreach (e[k]) begin
            for (int j = 0; j < 4; j++) begin
                i_sra_host_model.tw_rd(k == e.size() - 1 && j == 3, b);
                d = {d[23:0], b};
            end
            `CHK("tw read", e[k], d)
        end
        i_sra_host_model.tw_stop();
    endtask : tw_read
    task automatic tw_test();
        i_sra_host_model.tw_start();
        tw_send('{8'h8a, 8'h1e});
        i_sra_host_model.tw_start();
        repeat (9) i_sra_host_model.tw_bit(1'b1, ack_n);
        i_sra_host_model.tw_start();
        i_sra_host_model.tw_stop();
        i_sra_host_model.tw_start();
        tw_send('{8'h8a, 8'h1e, 8'h00, 8'h05, 8'h12, 8'h34, 8'h56, 8'h78,
            8'h9a, 8'hbc, 8'hde, 8'hf0});
        i_sra_host_model.tw_stop();
        `CHK("mem5", 32'h12345678, mem[5])
        `CHK("mem6", 32'h9abcdef0, mem[6])
        tw_read(8'h1e, 8'h00, 8'h05, '{32'h12345678, 32'h9abcdef0});
        tw_read(8'h7f, 8'h00, 8'h00, '{32'h0});
        i_sra_host_model.tw_start();
        i_sra_host_model.tw_wr(8'h8c, ack_n);
        `CHK("foreign addr", 1'b1, ack_n)
        i_sra_host_model.tw_stop();
        @(posedge mclk) paddr <= 3'h6;
        repeat (4) @(posedge mclk);
        i_sra_host_model.tw_start();
        i_sra_host_model.tw_wr(8'h8c, ack_n);
        `CHK("strap addr", 1'b0, ack_n)
        i_sra_host_model.tw_stop();
        $display("tw_test done");
    endtask : tw_test
    // watchdog: a hang counts as a mismatch
    initial begin
        #600000 failures++;
        stop_test();
    end
    initial begin
        foreach (mem[i]) mem[i] = 32'hc0c00000 | i;
        repeat (20) @(posedge mclk);
        srst <= 0;
        repeat (4) @(posedge mclk);
        test_reset();
        spi_seq(1'b0);
        spi_seq(1'b1);
        tw_test();
        stop_test();
    end
endmodule : testbench
